// ---- sopv_pkg.sv ----
// constants, types and state carrier for the serial program/verify port
// assumes a 12-bit word otp core with a 12-bit instruction pointer
package sopv_pkg;

   // command codes, six bits, sent lsb first
   localparam logic [5:0] CMD_LOAD = 6'h02;
   localparam logic [5:0] CMD_READ = 6'h04;
   localparam logic [5:0] CMD_INC = 6'h06;
   localparam logic [5:0] CMD_BEGIN = 6'h08;
   localparam logic [5:0] CMD_END = 6'h0E;

   // frame layout
   localparam int CMD_BITS = 6;
   localparam int FRAME_CYCLES = 16;
   localparam logic [3:0] CMD_LAST = 4'(CMD_BITS - 1);
   localparam logic [3:0] DATA_FIRST = 4'h1;
   localparam logic [3:0] DATA_LAST = 4'(FRAME_CYCLES - 2);
   localparam logic [3:0] FRAME_LAST = 4'(FRAME_CYCLES - 1);
   localparam logic [3:0] WORD_BITS = 4'hC;

   // address map in program/verify mode
   localparam logic [11:0] PTR_RESET = 12'hFFF;
   localparam logic [11:0] CFG_ADDR = 12'hFFF;
   localparam logic [11:0] OPEN_LAST = 12'h03F;
   localparam int USER_WORDS_DEF = 512;
   localparam int SPECIAL_WORDS = 64;

   // configuration word fields and erased value
   localparam logic [11:0] CFG_RESET = 12'hFFF;
   localparam int CFG_CLEAR_EN = 4;
   localparam int CFG_PROTECT = 3;
   localparam int CFG_WATCHDOG = 2;
   localparam int CFG_OSC_HI = 1;
   localparam int CFG_OSC_LO = 0;
   localparam logic [11:0] ERASED = 12'hFFF;

   // register bus map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CONFIG = 4'h8;
   localparam logic CTRL_RESET = 1'b1;

   typedef enum logic [1:0] {SOPV_OFF, SOPV_CMD, SOPV_DATA} sopv_phase_t;

   typedef struct packed {
      logic hv_s1, hv_s2, low_s1, low_s2;
      logic clk_s1, clk_s2, clk_d, dat_s1, dat_s2;
      logic armed, mode, is_read, moved, have_load;
      sopv_phase_t phase;
      logic [3:0] bitn;
      logic [5:0] cmd;
      logic [11:0] shift, loaded, rd_word, ptr, prog_addr, cfg;
      logic prog_active, prog_cfg, dout, doe, core_rst_n, port_en;
      logic av_wait;
      logic [31:0] av_rdata;
   } sopv_state_t;

endpackage

// ---- sopv_port.sv ----
// serial program/verify port with its otp array and an avalon-mm status slave
// assumes the programmer drives the clock pin and keeps the pin timing gaps
//
// Operation
// [R1] programmer enters mode with clock and data low while clear goes low to high volt
// [R2] in mode the rest of the chip is held in reset with pins released
// [R3] programmer should reach high voltage within 9 ms of supply rise
// [R4] clock pin is an input; data pin carries bits both ways
// [R5] commands are six bits lsb first, taken on falling clock edges
// [R6] programmer waits 1 us between command and data clocks
// [R7] data frame is 16 cycles: start bit, word lsb first, stop bit
// [R8] read drives data from second rising edge, releases after sixteenth
// [R9] load takes lsb on second falling edge, later bits on later falls
// [R10] programmer waits 1 us before the next command
// [R11] load, read and increment codes; load and read carry a frame
// [R12] begin command starts programming the addressed word with the loaded word
// [R13] end command stops the programming in progress
// [R14] two top bits of a loaded 14-bit field are dropped
// [R15] two top bits of a read field are sent as zero
// [R16] increment advances the instruction pointer by one
// [R17] programmer loads a fresh word before every begin command
// [R18] programmer uses 100 us pulses between begin and end
// [R19] config bits read 0 programmed; bit 4 enables external clear pin
// [R20] config bit 3 low protects code memory
// [R21] config bit 2 enables watchdog; bits 1-0 pick the oscillator
// [R22] words 0x000 to 0x03F stay readable and programmable when protected
// [R23] protected words read zero and refuse programming; special words stay open
// [R24] clear low forces the pointer to all ones, addressing the config word
// [R25] stepping past user memory reaches the special area with the id words
// [R26] load ignores data in the start and stop cycles
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module sopv_port
   import sopv_pkg::*;
#(
   parameter int USER_WORDS = USER_WORDS_DEF,
   parameter bit HAS_CAL_WORD = 1'b1
) (
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic CLEAR_LOW,
   input wire logic CLEAR_HV,
   input wire logic SCLK_IN,
   input wire logic SDATA_IN,
   output logic SDATA_OUT,
   output logic SDATA_OE,
   output logic CORE_RESET_N,
   output logic PROG_MODE,
   output logic PROG_PULSE,
   output logic CLEAR_PIN_ENABLE,
   output logic PROTECT_ENABLE,
   output logic WATCHDOG_ENABLE,
   output logic [1:0] OSC_SELECT,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST
);

   localparam int MEM_WORDS = USER_WORDS + SPECIAL_WORDS;
   localparam int AW = $clog2(MEM_WORDS);
   localparam logic [11:0] USER_LIM = 12'(USER_WORDS);
   localparam logic [11:0] MEM_LIM = 12'(MEM_WORDS);
   localparam logic [11:0] CAL_ADDR = 12'(USER_WORDS - 1);

   // the special area must fit below the config word
   if (USER_WORDS <= 64 || MEM_WORDS >= 4095) begin : g_bad_size
      $error("sopv_port: USER_WORDS out of range");
   end

   sopv_state_t s;
   sopv_state_t next_s;
   logic [11:0] mem [MEM_WORDS];

   logic rise;
   logic fall;
   logic dec;
   logic [5:0] cmd_full;
   logic cfg_sel;
   logic in_mem;
   logic guarded;
   logic writable;
   logic [11:0] view;
   logic end_fire;
   logic [3:0] idx;
   logic [31:0] rd_mux;

   // array stands for unprogrammed cells; no reset, cells keep their charge
   initial begin
      for (int i = 0; i < MEM_WORDS; i++) begin
         mem[i] = ERASED;
      end
   end

   assign rise = s.clk_s2 & ~s.clk_d;
   assign fall = ~s.clk_s2 & s.clk_d;
   assign cmd_full = {s.dat_s2, s.cmd[5:1]};
   assign dec = s.mode && s.phase == SOPV_CMD && fall && s.bitn == CMD_LAST;
   // the config word is reachable only before the first increment
   assign cfg_sel = s.ptr == CFG_ADDR && !s.moved; // [R24]
   assign in_mem = s.ptr < MEM_LIM; // [R25]
   // low block, calibration word and special area stay open
   assign guarded = !s.cfg[CFG_PROTECT] && s.ptr > OPEN_LAST && s.ptr < USER_LIM
      && !(HAS_CAL_WORD && s.ptr == CAL_ADDR); // [R20] [R22]
   assign writable = cfg_sel || (in_mem && !guarded); // [R23]
   assign end_fire = dec && cmd_full == CMD_END && s.prog_active && !s.prog_cfg;
   assign idx = 4'(s.bitn - DATA_FIRST);

   always_comb begin
      view = 12'h000;
      if (cfg_sel) begin
         view = s.cfg;
      end else if (in_mem && !guarded) begin
         view = mem[s.ptr[AW-1:0]];
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (AVS_ADDRESS)
         REG_CTRL: begin
            rd_mux = {31'h0000_0000, s.port_en};
         end
         REG_STATUS: begin
            rd_mux = {4'h0, s.ptr, 12'h000, !s.cfg[CFG_PROTECT], s.have_load,
               s.prog_active, s.mode};
         end
         REG_CONFIG: begin
            rd_mux = {20'h0_0000, s.cfg};
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      next_s = s;
      // pins from the programmer pass two flops before use
      next_s.hv_s1 = CLEAR_HV;
      next_s.hv_s2 = s.hv_s1;
      next_s.low_s1 = CLEAR_LOW;
      next_s.low_s2 = s.low_s1;
      next_s.clk_s1 = SCLK_IN; // [R4]
      next_s.clk_s2 = s.clk_s1;
      next_s.clk_d = s.clk_s2;
      next_s.dat_s1 = SDATA_IN;
      next_s.dat_s2 = s.dat_s1;

      if (s.low_s2) begin
         next_s.armed = 1'b1;
         next_s.mode = 1'b0;
         next_s.phase = SOPV_OFF;
         next_s.ptr = PTR_RESET; // [R24]
         next_s.moved = 1'b0;
         next_s.prog_active = 1'b0;
         next_s.doe = 1'b0;
      end else if (!s.mode) begin
         if (s.armed && s.hv_s2 && !s.clk_s2 && !s.dat_s2 && s.port_en) begin
            next_s.mode = 1'b1;
            next_s.armed = 1'b0;
            next_s.phase = SOPV_CMD;
            next_s.bitn = 4'h0;
            next_s.have_load = 1'b0;
         end else if (s.hv_s2) begin
            // a refused entry waits for a fresh clear low; a slow rise stays armed
            next_s.armed = 1'b0;
         end
      end else if (!s.hv_s2) begin
         // leaving the mode aborts a pulse without touching the cell
         next_s.mode = 1'b0;
         next_s.phase = SOPV_OFF;
         next_s.prog_active = 1'b0;
         next_s.doe = 1'b0;
      end else begin
         case (s.phase)
            SOPV_CMD: begin
               if (fall) begin
                  next_s.cmd = cmd_full; // [R5]
                  next_s.bitn = 4'(s.bitn + 4'h1);
               end
               if (dec) begin
                  next_s.bitn = 4'h0;
                  case (cmd_full) // [R11]
                     CMD_LOAD: begin
                        next_s.phase = SOPV_DATA;
                        next_s.is_read = 1'b0;
                        next_s.shift = 12'h000;
                     end
                     CMD_READ: begin
                        next_s.phase = SOPV_DATA;
                        next_s.is_read = 1'b1;
                        next_s.rd_word = view; // [R23]
                     end
                     CMD_INC: begin
                        next_s.ptr = 12'(s.ptr + 12'h001); // [R16]
                        next_s.moved = 1'b1;
                     end
                     CMD_BEGIN: begin
                        // a word is used once; a refused begin leaves no pulse
                        if (s.have_load && writable && !s.prog_active) begin
                           next_s.prog_active = 1'b1; // [R12] [R17]
                           next_s.prog_addr = s.ptr;
                           next_s.prog_cfg = cfg_sel;
                        end
                        next_s.have_load = 1'b0;
                     end
                     CMD_END: begin
                        if (s.prog_active) begin
                           next_s.prog_active = 1'b0; // [R13]
                           if (s.prog_cfg) begin
                              next_s.cfg = s.cfg & s.loaded; // [R19]
                           end
                        end
                     end
                     default: begin
                        next_s.phase = SOPV_CMD;
                     end
                  endcase
               end
            end
            SOPV_DATA: begin
               if (rise && s.is_read) begin
                  if (s.bitn >= DATA_FIRST && s.bitn <= DATA_LAST) begin
                     next_s.doe = 1'b1; // [R8]
                     next_s.dout = (idx < WORD_BITS) ? s.rd_word[idx] : 1'b0; // [R15]
                  end else if (s.bitn == FRAME_LAST) begin
                     next_s.doe = 1'b0; // [R8]
                     next_s.dout = 1'b0;
                  end
               end
               if (fall) begin
                  next_s.bitn = 4'(s.bitn + 4'h1); // [R7]
                  if (!s.is_read && s.bitn >= DATA_FIRST && idx < WORD_BITS) begin
                     next_s.shift[idx] = s.dat_s2; // [R9] [R14] [R26]
                  end
                  if (s.bitn == FRAME_LAST) begin
                     next_s.phase = SOPV_CMD;
                     next_s.bitn = 4'h0;
                     if (!s.is_read) begin
                        next_s.loaded = s.shift;
                        next_s.have_load = 1'b1;
                     end
                  end
               end
            end
            default: begin
               next_s.phase = SOPV_CMD;
               next_s.bitn = 4'h0;
            end
         endcase
      end

      next_s.core_rst_n = !(next_s.mode || s.low_s2); // [R2]

      // avalon slave: one wait cycle, then the request is taken
      if (s.av_wait) begin
         if (AVS_READ || AVS_WRITE) begin
            next_s.av_wait = 1'b0;
            next_s.av_rdata = AVS_READ ? rd_mux : 32'h0000_0000;
         end
      end else begin
         next_s.av_wait = 1'b1;
         if (AVS_WRITE && AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0]) begin
            next_s.port_en = AVS_WRITEDATA[0];
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         s <= '0;
         s.phase <= SOPV_OFF;
         s.ptr <= PTR_RESET;
         s.cfg <= CFG_RESET;
         s.loaded <= ERASED;
         s.core_rst_n <= 1'b0;
         s.port_en <= CTRL_RESET;
         s.av_wait <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // otp cells only ever clear bits, so the write is a merge
   always_ff @(posedge REF_CLK) begin
      if (end_fire) begin
         mem[s.prog_addr[AW-1:0]] <= mem[s.prog_addr[AW-1:0]] & s.loaded; // [R13]
      end
   end

   assign SDATA_OUT = s.dout;
   assign SDATA_OE = s.doe;
   assign CORE_RESET_N = s.core_rst_n;
   assign PROG_MODE = s.mode;
   assign PROG_PULSE = s.prog_active;
   assign CLEAR_PIN_ENABLE = s.cfg[CFG_CLEAR_EN]; // [R19]
   assign PROTECT_ENABLE = !s.cfg[CFG_PROTECT]; // [R20]
   assign WATCHDOG_ENABLE = s.cfg[CFG_WATCHDOG]; // [R21]
   assign OSC_SELECT = s.cfg[CFG_OSC_HI:CFG_OSC_LO]; // [R21]
   assign AVS_READDATA = s.av_rdata;
   assign AVS_WAITREQUEST = s.av_wait;

   AST_CORE_HELD: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R2]
      s.mode && $past(s.mode) |-> !CORE_RESET_N) else $error("core not held");
   AST_CMD_LENGTH: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R5]
      s.phase == SOPV_DATA && $past(s.phase) == SOPV_CMD |-> $past(s.bitn) == CMD_LAST)
      else $error("frame after short command");
   AST_OE_FRAME: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R8]
      SDATA_OE |-> s.phase == SOPV_DATA && s.is_read && s.bitn >= DATA_FIRST)
      else $error("data driven outside read");
   AST_TOP_ZERO: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R15]
      SDATA_OE && s.bitn >= DATA_LAST |-> !SDATA_OUT)
      else $error("top bits not zero");
   AST_INC: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R16]
      dec && cmd_full == CMD_INC && !s.low_s2 && s.hv_s2
      |=> s.ptr == 12'($past(s.ptr) + 12'h001)) else $error("pointer not advanced");
   AST_BEGIN: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R12]
      dec && cmd_full == CMD_BEGIN && !s.low_s2 && s.hv_s2 && s.have_load && writable
      && !s.prog_active |=> PROG_PULSE ##1 PROG_PULSE) else $error("pulse not started");
   AST_END: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R13]
      dec && cmd_full == CMD_END |=> !PROG_PULSE) else $error("pulse not stopped");
   AST_ENTRY_PTR: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R24]
      $rose(s.mode) |-> s.ptr == PTR_RESET && cfg_sel) else $error("bad entry pointer");
   AST_GUARD: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R23]
      dec && cmd_full == CMD_READ && !s.low_s2 && s.hv_s2 && guarded
      |=> s.rd_word == 12'h000) else $error("protected word leaked");
   // the low block must take a pulse whatever the protection bit says
   AST_OPEN_LOW: assert property (@(posedge REF_CLK) disable iff (!NRST) // [R22]
      dec && cmd_full == CMD_BEGIN && !s.low_s2 && s.hv_s2 && s.have_load && !s.prog_active
      && s.ptr <= OPEN_LAST |=> PROG_PULSE) else $error("low block refused");

   COV_ENTRY: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(s.mode));
   COV_READ: cover property (@(posedge REF_CLK) disable iff (!NRST) $fell(SDATA_OE));
   COV_LOAD: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(s.have_load));
   COV_PULSE: cover property (@(posedge REF_CLK) disable iff (!NRST) $fell(PROG_PULSE));

endmodule

// ---- sopv_prog_model.sv ----
// programmer model for the serial program/verify port: drives the clock pin and data pin
// assumes a 200 MHz reference clock; one serial bit takes 16 reference cycles (80 ns)
`timescale 1ns/1ps
module sopv_prog_model (
   input wire logic ref_clk,
   input wire logic dev_out,
   input wire logic dev_oe,
   output logic sclk,
   output logic sdata_pin
);
   logic drv = 1'h0;
   logic drv_en = 1'h1;
   logic tog = 1'h0;

   initial sclk = 1'h0;

   // a released line floats, so show a toggling level rather than a stale bit
   always @(posedge ref_clk) tog <= ~tog;
   assign sdata_pin = dev_oe ? dev_out : (drv_en ? drv : tog);

   // one serial cycle: data changes with the rise, pin sampled late in the high phase
   task automatic clk_bit(input logic b, output logic s, output logic o);
      @(posedge ref_clk);
      sclk <= 1'h1;
      drv <= b;
      repeat (7) @(posedge ref_clk);
      @(negedge ref_clk);
      s = sdata_pin;
      o = dev_oe;
      @(posedge ref_clk);
      sclk <= 1'h0;
      repeat (7) @(posedge ref_clk);
   endtask

   // clock and data rest low between words (data floats only in the gap after a read), so a mode entry always sees both low
   task automatic gap();
      drv <= 1'h0;
      sclk <= 1'h0;
      repeat (210) @(posedge ref_clk);
   endtask

   task automatic send_cmd(input logic [5:0] c);
      logic s, o;
      for (int i = 0; i < 6; i++) clk_bit(c[i], s, o);
      gap();
   endtask

   // start and stop bits sent high on purpose: the device has to drop them
   task automatic load_word(input logic [13:0] w);
      logic s, o;
      clk_bit(1'h1, s, o);
      for (int i = 0; i < 14; i++) clk_bit(w[i], s, o);
      clk_bit(1'h1, s, o);
      gap();
   endtask

   task automatic read_word(output logic [13:0] w, output logic [15:0] oe);
      logic s;
      drv_en <= 1'h0;
      for (int i = 0; i < 16; i++) begin
         clk_bit(1'h0, s, oe[i]);
         if (i >= 1 && i <= 14) w[i - 1] = s;
      end
      gap();
      drv_en <= 1'h1;
   endtask

   task automatic hold_pulse();
      repeat (20000) @(posedge ref_clk);
   endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the serial program/verify port
// assumes sopv_prog_model plays the programmer; bus tasks start right after a rising edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top
   import sopv_pkg::*;
;
   logic ref_clk = 1'h0;
   logic nrst = 1'h0;
   logic clear_low = 1'h0;
   logic clear_hv = 1'h0;
   logic sclk, sdata_in, sdata_out, sdata_oe, core_reset_n, prog_mode, prog_pulse;
   logic clear_pin_enable, protect_enable, watchdog_enable;
   logic [1:0] osc_select;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;

   always #2.5 ref_clk = ~ref_clk;

   sopv_port i_sopv_port (.REF_CLK(ref_clk), .NRST(nrst), .CLEAR_LOW(clear_low),
      .CLEAR_HV(clear_hv), .SCLK_IN(sclk), .SDATA_IN(sdata_in), .SDATA_OUT(sdata_out),
      .SDATA_OE(sdata_oe), .CORE_RESET_N(core_reset_n), .PROG_MODE(prog_mode),
      .PROG_PULSE(prog_pulse), .CLEAR_PIN_ENABLE(clear_pin_enable),
      .PROTECT_ENABLE(protect_enable), .WATCHDOG_ENABLE(watchdog_enable),
      .OSC_SELECT(osc_select), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));

   sopv_prog_model prog (.ref_clk(ref_clk), .dev_out(sdata_out), .dev_oe(sdata_oe),
      .sclk(sclk), .sdata_pin(sdata_in));

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // three pulses of 100 us dominate the run (about 92k cycles); the ceiling sits just above
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 100000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
         output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~wr;
      avs_write <= wr;
      @(posedge ref_clk);
      // no local limit: only the bench ceiling ends a stuck wait
      while (avs_waitrequest !== 1'h0) begin
         @(posedge ref_clk);
      end
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge ref_clk);
   endtask

   task automatic enter_mode();
      clear_hv <= 1'h0;
      clear_low <= 1'h1;
      repeat (8) @(posedge ref_clk);
      clear_low <= 1'h0;
      clear_hv <= 1'h1;
      repeat (8) @(posedge ref_clk);
   endtask

   task automatic chk_ptr(input logic [11:0] e);
      logic [31:0] q;
      av_xfer(1'h0, REG_STATUS, 32'h0000_0000, q);
      `CHK("pointer", e, q[27:16])
   endtask

   task automatic chk_read(input logic [13:0] e);
      logic [13:0] w;
      logic [15:0] oe;
      prog.send_cmd(CMD_READ);
      prog.read_word(w, oe);
      `CHK("read word", e, w)
      `CHK("data pin enable", 16'h7FFE, oe)
      `CHK("pin released", 1'h0, sdata_oe)
   endtask

   task automatic program_word(input logic [13:0] w);
      prog.send_cmd(CMD_LOAD);
      prog.load_word(w);
      prog.send_cmd(CMD_BEGIN);
      `CHK("pulse on", 1'h1, prog_pulse)
      prog.hold_pulse();
      prog.send_cmd(CMD_END);
      `CHK("pulse off", 1'h0, prog_pulse)
   endtask

   task automatic t_regs();
      logic [31:0] q;
      `CHK("clear pin enable", 1'h1, clear_pin_enable)
      `CHK("protect", 1'h0, protect_enable)
      `CHK("watchdog", 1'h1, watchdog_enable)
      `CHK("oscillator", 2'h3, osc_select)
      `CHK("core reset", 1'h1, core_reset_n)
      av_xfer(1'h0, REG_CONFIG, 32'h0000_0000, q);
      `CHK("config reg", 32'h0000_0FFF, q)
      av_xfer(1'h0, 4'hC, 32'h0000_0000, q);
      `CHK("unmapped", 32'h0000_0000, q)
      av_xfer(1'h1, REG_CTRL, 32'h0000_0000, q);
      av_xfer(1'h0, REG_CTRL, 32'h0000_0000, q);
      `CHK("ctrl", 1'h0, q[0])
      enter_mode();
      `CHK("mode refused", 1'h0, prog_mode)
      av_xfer(1'h1, REG_CTRL, 32'h0000_0001, q);
      // high voltage still applied: enabling the port must not enter without a new clear low
      repeat (8) @(posedge ref_clk);
      `CHK("late entry", 1'h0, prog_mode)
      av_xfer(1'h0, REG_CTRL, 32'h0000_0000, q);
      `CHK("ctrl on", 1'h1, q[0])
   endtask

   task automatic t_program();
      enter_mode();
      `CHK("mode", 1'h1, prog_mode)
      `CHK("core held", 1'h0, core_reset_n)
      `CHK("pin idle", 1'h0, sdata_oe)
      chk_ptr(12'hFFF);
      chk_read(14'h0FFF);
      prog.send_cmd(CMD_BEGIN);
      `CHK("begin refused", 1'h0, prog_pulse)
      prog.send_cmd(CMD_END);
      prog.send_cmd(CMD_INC);
      chk_ptr(12'h000);
      program_word(14'h3A5A);
      chk_read(14'h0A5A);
   endtask

   // config 0x012: clear pin on, protected, watchdog off, internal rc
   task automatic t_config();
      logic [31:0] q;
      enter_mode();
      chk_ptr(12'hFFF);
      program_word(14'h3012);
      `CHK("protect on", 1'h1, protect_enable)
      `CHK("clear pin", 1'h1, clear_pin_enable)
      `CHK("watchdog off", 1'h0, watchdog_enable)
      `CHK("osc", 2'h2, osc_select)
      av_xfer(1'h0, REG_CONFIG, 32'h0000_0000, q);
      `CHK("config reg", 32'h0000_0012, q)
      chk_read(14'h0012);
   endtask

   task automatic t_protect();
      prog.send_cmd(CMD_INC);
      chk_read(14'h0A5A);
      // the low block still takes a pulse under protection; cells only lose ones
      program_word(14'h3A50);
      chk_read(14'h0A50);
      for (int i = 0; i < 63; i++) prog.send_cmd(CMD_INC);
      chk_ptr(12'h03F);
      chk_read(14'h0FFF);
      prog.send_cmd(CMD_INC);
      chk_read(14'h0000);
      prog.send_cmd(CMD_LOAD);
      prog.load_word(14'h0000);
      prog.send_cmd(CMD_BEGIN);
      `CHK("protected begin", 1'h0, prog_pulse)
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'h1;
      repeat (4) @(posedge ref_clk);
      t_regs();
      t_program();
      t_config();
      t_protect();
      print_verdict();
   end
endmodule
